// ---- rtl/adc_seq_defines.vh ----
// Timing constants for the converter read sequencer.
// Assumes a 20 MHz system clock; counts are derived here, ns counts rounded up for minimums.
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

`define CLK_PERIOD_NS       50
// Minimum times in their own units
`define T_CNCS_NS           10
`define T_CSBSY_NS          40
`define T_BSYCS_NS          0
`define T_CSCN_NS           10
`define T_CSCK_NS           8
`define T_CKCS_NS           10
`define T_OS_NS             20
`define T_STBYCN_US         100
`define T_RSTSHUT_INT_MS    50
`define T_RSTSHUT_EXT_MS    13
`define T_RSTCN_US          25
`define T_ACQ_US            1
`define T_RST_PH_NS         50
`define T_CNV_PH_NS         25
`define T_RD_PL_NS          15
`define T_RD_PH_NS          15
// Cycle counts; ns counts rounded up, never below one; us and ms counts truncated
`define CYC_NS(t)  ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                    (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_US(t)  (((t) * 1000) / `CLK_PERIOD_NS)
`define CYC_MS(t)  (((t) * 1000000) / `CLK_PERIOD_NS)

`define N_SERIAL_BITS       16
`define N_CHANNELS          8
`define SCLK_HALF_CYC       1

`endif

// ---- rtl/delay_timer.v ----
// Down-counting interval timer: load a count, done pulses when it expires.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module delay_timer #(
    parameter WIDTH = 24
) (
    input  wire             mclk_i,   // System clock
    input  wire             rst_i,    // Sync reset
    input  wire             load_i,   // Start interval
    input  wire [WIDTH-1:0] count_i,  // Cycles to wait, at least one
    output reg              busy_o,   // Interval running
    output reg              done_o    // One-cycle expiry pulse
);
    reg [WIDTH-1:0] cnt_reg;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_reg <= {WIDTH{1'b0}};
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt_reg <= count_i;
                busy_o  <= 1'b1;
            end else if (busy_o) begin
                if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/adc_read_sequencing.v ----
// Host-side sequencer for an eight-channel simultaneous-sampling converter:
// conversion start, read after conversion, standby and shutdown exits.
// Assumes busy and serial data are synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.vh"
module adc_read_sequencing #(
    parameter STANDBY_CONTROL_N_CYC     = `CYC_US(`T_STBYCN_US),
    parameter SHUT_INT_CYC = `CYC_MS(`T_RSTSHUT_INT_MS),
    parameter SHUT_EXT_CYC = `CYC_MS(`T_RSTSHUT_EXT_MS),
    parameter RSTCN_CYC    = `CYC_US(`T_RSTCN_US),
    parameter ACQ_CYC      = `CYC_US(`T_ACQ_US)
) (
    input  wire        mclk_i,                   // System clock, 20 MHz
    input  wire        rst_i,                    // Sync reset, active high
    input  wire        sample_req_i,             // Pulse: start one conversion and read
    input  wire        wake_req_i,               // Pulse: leave standby
    input  wire        shutdown_exit_i,          // Pulse: leave shutdown (wake plus reset)
    input  wire        ext_ref_i,                // External reference in use
    input  wire        sleep_req_i,              // Pulse: enter standby
    input  wire [2:0]  os_ratio_i,               // Requested oversampling ratio code
    input  wire        busy_i,                   // Converter busy indication
    input  wire        serial_out_a_i,           // Serial data, channels 1-4
    input  wire        serial_out_b_i,           // Serial data, channels 5-8
    output reg         convert_start_group_a_o,  // Start strobe group A
    output reg         convert_start_group_b_o,  // Start strobe group B
    output reg         standby_control_n_o,      // Low puts converter in standby
    output reg         dev_reset_o,              // Converter reset pulse
    output reg  [2:0]  oversample_ratio_select_o,// Ratio select pins
    output reg         cs_n_o,                   // Chip select, active low
    output reg         sclk_o,                   // Serial clock, idles high
    output reg  [15:0] data_a_o,                 // Word from serial_out_a
    output reg  [15:0] data_b_o,                 // Word from serial_out_b
    output reg  [1:0]  chan_idx_o,               // Word pair index within sample
    output reg         data_valid_o,             // Pulse: data words valid
    output reg         discard_o,                // Drop flag; always low, as no result is ever marked to drop
    output reg         ready_o                   // Idle and awake
);
    localparam S_ASLEEP = 4'h0, S_WAKE = 4'h1, S_RST_HI = 4'h2, S_RST_WAIT = 4'h3,
               S_IDLE = 4'h4, S_CNV = 4'h5, S_BUSY = 4'h6, S_CS_SETUP = 4'h7,
               S_SHIFT = 4'h8, S_CS_HOLD = 4'h9, S_ACQ = 4'ha;

    localparam TW = 27;
    reg  [3:0]    state_reg;
    reg  [TW-1:0] tload_cnt;
    reg           tload;
    wire          t_busy;
    wire          t_done;
    reg  [4:0]    bit_cnt_reg;
    reg  [2:0]    word_cnt_reg;
    reg           busy_d_reg;
    reg           discard_pend_reg;
    reg  [15:0]   sh_a_reg;
    reg  [15:0]   sh_b_reg;

    function [TW-1:0] cyc;
        input integer n;
        begin
            cyc = n[TW-1:0];
        end
    endfunction

    delay_timer #(.WIDTH(TW)) u_timer (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .load_i  (tload),
        .count_i (tload_cnt),
        .busy_o  (t_busy),
        .done_o  (t_done)
    );

    // Timer load decisions, taken from state and events
    always @* begin
        tload     = 1'b0;
        tload_cnt = cyc(1);
        case (state_reg)
            S_ASLEEP: begin
                if (shutdown_exit_i) begin
                    tload     = 1'b1;
                    tload_cnt = ext_ref_i ? cyc(SHUT_EXT_CYC) : cyc(SHUT_INT_CYC);
                end else if (wake_req_i) begin
                    tload     = 1'b1;
                    tload_cnt = cyc(STANDBY_CONTROL_N_CYC);
                end
            end
            S_RST_HI: begin
                if (t_done) begin
                    tload     = 1'b1;
                    tload_cnt = cyc(RSTCN_CYC);
                end
            end
            S_WAKE: begin
                if (t_done && !dev_reset_o && standby_control_n_o && bit_cnt_reg[0]) begin
                    tload     = 1'b1;
                    tload_cnt = cyc(`CYC_NS(`T_RST_PH_NS));
                end
            end
            S_BUSY: begin
                if (busy_d_reg && !busy_i) begin
                    tload     = 1'b1;
                    tload_cnt = cyc(ACQ_CYC);
                end
            end
            default: begin
                tload     = 1'b0;
                tload_cnt = cyc(1);
            end
        endcase
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg                 <= S_ASLEEP;
            convert_start_group_a_o   <= 1'b0;
            convert_start_group_b_o   <= 1'b0;
            standby_control_n_o       <= 1'b0;
            dev_reset_o               <= 1'b0;
            oversample_ratio_select_o <= 3'h0;
            cs_n_o                    <= 1'b1;
            sclk_o                    <= 1'b1;
            data_a_o                  <= 16'h0000;
            data_b_o                  <= 16'h0000;
            chan_idx_o                <= 2'h0;
            data_valid_o              <= 1'b0;
            discard_o                 <= 1'b0;
            ready_o                   <= 1'b0;
            bit_cnt_reg               <= 5'h00;
            word_cnt_reg              <= 3'h0;
            busy_d_reg                <= 1'b0;
            discard_pend_reg          <= 1'b0;
            sh_a_reg                  <= 16'h0000;
            sh_b_reg                  <= 16'h0000;
        end else begin
            busy_d_reg   <= busy_i;
            data_valid_o <= 1'b0;
            case (state_reg)
                S_ASLEEP: begin
                    ready_o <= 1'b0;
                    if (shutdown_exit_i) begin
                        standby_control_n_o <= 1'b1;
                        bit_cnt_reg         <= 5'h01; // Marks the shutdown path
                        state_reg           <= S_WAKE;
                    end else if (wake_req_i) begin
                        standby_control_n_o <= 1'b1;
                        bit_cnt_reg         <= 5'h00;
                        state_reg           <= S_WAKE;
                    end
                end
                S_WAKE: begin
                    if (t_done) begin
                        if (bit_cnt_reg[0]) begin
                            dev_reset_o <= 1'b1;
                            state_reg   <= S_RST_HI;
                        end else begin
                            discard_pend_reg <= 1'b0;
                            ready_o          <= 1'b1;
                            state_reg        <= S_IDLE;
                        end
                    end
                end
                S_RST_HI: begin
                    // Reset held one cycle (50 ns); cleared on the first cycle in this state
                    dev_reset_o <= 1'b0;
                    if (t_done || !t_busy) begin
                        state_reg <= S_RST_WAIT;
                    end
                end
                S_RST_WAIT: begin
                    if (t_done) begin
                        discard_pend_reg <= 1'b0;
                        ready_o          <= 1'b1;
                        state_reg        <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (sleep_req_i) begin
                        standby_control_n_o <= 1'b0;
                        ready_o             <= 1'b0;
                        state_reg           <= S_ASLEEP;
                    end else if (sample_req_i) begin
                        oversample_ratio_select_o <= os_ratio_i;
                        // Both strobes rise together, far inside the skew limit
                        convert_start_group_a_o   <= 1'b1;
                        convert_start_group_b_o   <= 1'b1;
                        ready_o                   <= 1'b0;
                        state_reg                 <= S_CNV;
                    end
                end
                S_CNV: begin
                    // One 50 ns high phase covers the 25 ns pulse minimum
                    convert_start_group_a_o <= 1'b0;
                    convert_start_group_b_o <= 1'b0;
                    state_reg               <= S_BUSY;
                end
                S_BUSY: begin
                    // Ratio pins stay frozen until the read is done, past busy falling
                    if (busy_d_reg && !busy_i) begin
                        // Reads start only once busy has fallen, never during a conversion;
                        // serial only, so select alone frames them and no read strobe exists
                        cs_n_o       <= 1'b0;
                        bit_cnt_reg  <= 5'h00;
                        word_cnt_reg <= 3'h0;
                        state_reg    <= S_CS_SETUP;
                    end
                end
                S_CS_SETUP: begin
                    sclk_o    <= 1'b0;
                    state_reg <= S_SHIFT;
                end
                S_SHIFT: begin
                    // Data is sampled at the rising edge the host makes
                    if (!sclk_o) begin
                        sclk_o   <= 1'b1;
                        sh_a_reg <= {sh_a_reg[14:0], serial_out_a_i};
                        sh_b_reg <= {sh_b_reg[14:0], serial_out_b_i};
                        if (bit_cnt_reg == (`N_SERIAL_BITS - 1)) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg   <= S_CS_HOLD;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end else begin
                        sclk_o <= 1'b0;
                    end
                end
                S_CS_HOLD: begin
                    data_a_o     <= sh_a_reg;
                    data_b_o     <= sh_b_reg;
                    chan_idx_o   <= word_cnt_reg[1:0];
                    discard_o    <= discard_pend_reg;
                    data_valid_o <= 1'b1;
                    if (word_cnt_reg == ((`N_CHANNELS / 2) - 1)) begin
                        cs_n_o    <= 1'b1;
                        state_reg <= S_ACQ;
                    end else begin
                        word_cnt_reg <= word_cnt_reg + 3'h1;
                        sclk_o       <= 1'b0;
                        state_reg    <= S_SHIFT;
                    end
                end
                S_ACQ: begin
                    // Select-to-start spacing comes from this state and idle, at least two cycles
                    if (!t_busy && !tload) begin
                        discard_pend_reg <= 1'b0;
                        ready_o          <= 1'b1;
                        state_reg        <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_ASLEEP;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verif/adc_seq_checker.sv ----
// Pin timing checks for the converter sequencer, seen at its top ports.
// Assumes it is bound into adc_read_sequencing with the same timing parameters.
`timescale 1ns/1ns
`default_nettype none
module adc_seq_checker #(
    parameter STANDBY_CONTROL_N_CYC     = 2000,
    parameter SHUT_INT_CYC = 1000000,
    parameter SHUT_EXT_CYC = 260000,
    parameter RSTCN_CYC    = 500,
    parameter ACQ_CYC      = 20
) (
    input wire logic       mclk_i,                    // Clock
    input wire logic       rst_i,                     // Reset
    input wire logic       sample_req_i,              // Sample request
    input wire logic       sleep_req_i,               // Sleep request
    input wire logic       shutdown_exit_i,           // Shutdown exit
    input wire logic       ext_ref_i,                 // External reference
    input wire logic [2:0] os_ratio_i,                // Ratio request
    input wire logic       busy_i,                    // Busy
    input wire logic       ready_o,                   // Ready
    input wire logic       convert_start_group_a_o,   // Start A
    input wire logic       convert_start_group_b_o,   // Start B
    input wire logic       standby_control_n_o,       // Standby, low active
    input wire logic       dev_reset_o,               // Device reset
    input wire logic [2:0] oversample_ratio_select_o, // Ratio pins
    input wire logic       cs_n_o,                    // Select
    input wire logic       sclk_o                     // Serial clock
);
    int   standby_control_n_cnt;
    int   idle_cnt;
    int   rst_cnt;
    logic ref_ext;
    // Counters saturate so a long idle stretch cannot wrap into a false short gap
    always @(posedge mclk_i) begin
        if (rst_i) begin
            standby_control_n_cnt <= 0;
            idle_cnt <= 1 << 30;
            rst_cnt  <= 1 << 30;
            ref_ext  <= 1'b0;
        end else begin
            standby_control_n_cnt <= !standby_control_n_o ? 0 : standby_control_n_cnt + int'(standby_control_n_cnt < (1 << 30));
            idle_cnt <= busy_i ? 0 : idle_cnt + int'(idle_cnt < (1 << 30));
            rst_cnt  <= dev_reset_o ? 0 : rst_cnt + int'(rst_cnt < (1 << 30));
            if (shutdown_exit_i)
                ref_ext <= ext_ref_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_CS_AFTER_BUSY: assert property ($fell(cs_n_o) |-> !$past(busy_i))
        else $error("Select fell while busy high");
    AST_CS_HIGH_AT_START: assert property ($rose(convert_start_group_a_o) |-> cs_n_o && $past(cs_n_o))
        else $error("Start raised without select high");
    AST_SELECT_BEFORE_SCLK: assert property ($fell(sclk_o) |-> !cs_n_o && !$past(cs_n_o))
        else $error("Serial clock moved too soon after select");
    AST_SELECT_HOLD: assert property ($rose(cs_n_o) |-> sclk_o && $past(sclk_o))
        else $error("Select released too soon after clock edge");
    AST_RATIO_STABLE: assert property ($past(busy_i) |-> $stable(oversample_ratio_select_o))
        else $error("Ratio pins moved around busy");
    AST_RATIO_LATCH: assert property (sample_req_i && ready_o && !sleep_req_i |=> oversample_ratio_select_o == $past(os_ratio_i))
        else $error("Ratio pins not set from request");
    AST_STANDBY_WAIT: assert property ($rose(convert_start_group_a_o) |-> standby_control_n_cnt >= STANDBY_CONTROL_N_CYC)
        else $error("Start too soon after standby exit");
    AST_SHUTDOWN_WAIT: assert property ($rose(dev_reset_o) |-> standby_control_n_cnt >= (ref_ext ? SHUT_EXT_CYC : SHUT_INT_CYC))
        else $error("Reset too soon after wake");
    AST_RESET_TO_START: assert property ($rose(convert_start_group_a_o) |-> rst_cnt >= RSTCN_CYC)
        else $error("Start too soon after reset");
    AST_ACQ_TIME: assert property ($rose(convert_start_group_a_o) |-> idle_cnt >= ACQ_CYC)
        else $error("Acquisition time too short");
    AST_STARTS_PAIRED: assert property (convert_start_group_a_o == convert_start_group_b_o)
        else $error("Start strobes apart");
    AST_START_PULSE: assert property (sample_req_i && ready_o && !sleep_req_i |=> convert_start_group_a_o ##1 !convert_start_group_a_o)
        else $error("Start pulse not one cycle after request");
endmodule
`default_nettype wire

// ---- verif/adc_device_model.sv ----
// Behavioural converter: busy timing by ratio and serial words on two lines.
// Assumes the host clock as time base; released data lines toggle every cycle.
`timescale 1ns/1ns
`default_nettype none
module adc_device_model #(
    parameter CONV_CYC = 8                                 // Busy cycles at ratio 0
) (
    input  wire logic       mclk_i,                        // Time base
    input  wire logic       convert_start_group_a_i,       // Start A
    input  wire logic       convert_start_group_b_i,       // Start B
    input  wire logic       standby_control_n_i,           // Low is standby
    input  wire logic [2:0] oversample_ratio_select_i,     // Ratio pins
    input  wire logic       cs_n_i,                        // Select
    input  wire logic       sclk_i,                        // Serial clock
    output wire logic       busy_o,                        // Busy
    output wire logic       serial_out_a_o,                // Data A
    output wire logic       serial_out_b_o                 // Data B
);
    logic       busy_reg = 1'b0;
    logic [9:0] conv_cnt = 10'h000;
    logic [7:0] sample_cnt = 8'h00;
    logic [5:0] shown = 6'h00;
    logic       sclk_q = 1'b1;
    logic       junk = 1'b0;
    wire  [15:0] word_a = {sample_cnt, 6'h0c, shown[5:4]};
    wire  [15:0] word_b = {~sample_cnt, 6'h30, shown[5:4]};
    assign busy_o = busy_reg | (convert_start_group_a_i & convert_start_group_b_i);
    assign serial_out_a_o = cs_n_i ? junk : word_a[~shown[3:0]];
    assign serial_out_b_o = cs_n_i ? ~junk : word_b[~shown[3:0]];
    always @(posedge mclk_i) begin
        sclk_q <= sclk_i;
        junk <= ~junk;
        if (busy_reg) begin
            conv_cnt <= conv_cnt - 10'h001;
            busy_reg <= (conv_cnt != 10'h001);
        end else if (convert_start_group_a_i && convert_start_group_b_i && standby_control_n_i) begin
            busy_reg <= 1'b1;
            conv_cnt <= 10'(CONV_CYC << oversample_ratio_select_i);
            sample_cnt <= sample_cnt + 8'h01;
        end
        // Next bit appears one cycle after the rise so the host sees it stable
        if (cs_n_i)
            shown <= 6'h00;
        else if (sclk_i && !sclk_q)
            shown <= shown + 6'h01;
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Bench for the converter sequencer: wake, samples at ratios 0 to 6, sleep, shutdown exits.
// Assumes the device model on the far side and the checker bound below.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam STANDBY_CONTROL_N = 40, SHUT_INT = 60, SHUT_EXT = 30, RSTCN = 20, ACQ = 20;
    logic mclk_i = 1'b0, rst_i = 1'b1, smp = 1'b0, wake = 1'b0, shut = 1'b0, ext = 1'b0, slp = 1'b0;
    logic [2:0] ratio = 3'h0;
    logic [7:0] exp_s = 8'h00;
    wire logic busy, sda, sdb, st_a, st_b, standby_control_n_n, dev_rst, cs_n, sclk, valid, ready, disc;
    wire logic [2:0] os_sel;
    wire logic [15:0] data_a, data_b;
    wire logic [1:0] idx;
    int error_cnt = 0, total_checks = 0, cycles = 0, n, i;
    adc_read_sequencing #(.STANDBY_CONTROL_N_CYC(STANDBY_CONTROL_N), .SHUT_INT_CYC(SHUT_INT), .SHUT_EXT_CYC(SHUT_EXT),
        .RSTCN_CYC(RSTCN), .ACQ_CYC(ACQ)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
        .sample_req_i(smp), .wake_req_i(wake), .shutdown_exit_i(shut), .ext_ref_i(ext),
        .sleep_req_i(slp), .os_ratio_i(ratio), .busy_i(busy), .serial_out_a_i(sda),
        .serial_out_b_i(sdb), .convert_start_group_a_o(st_a), .convert_start_group_b_o(st_b),
        .standby_control_n_o(standby_control_n_n), .dev_reset_o(dev_rst), .oversample_ratio_select_o(os_sel),
        .cs_n_o(cs_n), .sclk_o(sclk), .data_a_o(data_a), .data_b_o(data_b), .chan_idx_o(idx),
        .data_valid_o(valid), .discard_o(disc), .ready_o(ready));
    adc_device_model dev (.mclk_i(mclk_i), .convert_start_group_a_i(st_a),
        .convert_start_group_b_i(st_b), .standby_control_n_i(standby_control_n_n),
        .oversample_ratio_select_i(os_sel), .cs_n_i(cs_n), .sclk_i(sclk), .busy_o(busy),
        .serial_out_a_o(sda), .serial_out_b_o(sdb));
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic req(input logic s, input logic w, input logic d, input logic z);
        @(posedge mclk_i);
        {smp, wake, shut, slp} <= {s, w, d, z};
        @(posedge mclk_i);
        {smp, wake, shut, slp} <= 4'h0;
    endtask
    // sel 0 waits for ready, 1 for device reset, 2 for a data word
    task automatic wait_on(input int sel, output int n);
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while ((sel == 0 ? ready : sel == 1 ? dev_rst : valid) !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            error_cnt++;
            $display("Error at %0t: wait %0d timed out", $time, sel);
        end
    endtask
    task automatic sample(input logic [2:0] r);
        int k;
        wait_on(0, k);
        exp_s++;
        @(posedge mclk_i);
        ratio <= r;
        req(1'b1, 1'b0, 1'b0, 1'b0);
        req(1'b1, 1'b0, 1'b0, 1'b0);
        @(negedge mclk_i);
        check({13'h0, os_sel}, {13'h0, r});
        for (k = 0; k < 4; k++) begin
            wait_on(2, n);
            check(data_a, {exp_s, 6'h0c, 2'(k)});
            check(data_b, {~exp_s, 6'h30, 2'(k)});
            check({14'h0, idx}, 16'(k));
            check({15'h0, disc}, 16'h0000);
        end
        $display("Sample at ratio %0d done", r);
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("Error at %0t: run timed out", $time);
            results();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        check({10'h0, standby_control_n_n, cs_n, sclk, st_a, ready, dev_rst}, 16'h0018);
        req(1'b0, 1'b1, 1'b0, 1'b0);
        wait_on(0, n);
        check(16'(n >= STANDBY_CONTROL_N), 16'h0001);
        $display("Wake test done");
        for (i = 0; i < 7; i++)
            sample(3'(i));
        wait_on(0, n);
        req(1'b1, 1'b0, 1'b0, 1'b1);
        @(negedge mclk_i);
        check({14'h0, st_a, standby_control_n_n}, 16'h0000);
        @(posedge mclk_i);
        ext <= 1'b1;
        req(1'b0, 1'b0, 1'b1, 1'b0);
        wait_on(1, n);
        check(16'(n > SHUT_EXT && n < SHUT_INT), 16'h0001);
        wait_on(0, n);
        check(16'(n >= RSTCN), 16'h0001);
        sample(3'h3);
        wait_on(0, n);
        req(1'b0, 1'b0, 1'b0, 1'b1);
        ext <= 1'b0;
        req(1'b0, 1'b0, 1'b1, 1'b0);
        wait_on(1, n);
        check(16'(n > SHUT_INT), 16'h0001);
        sample(3'h6);
        $display("Sleep and shutdown tests done");
        results();
    end
endmodule
bind adc_read_sequencing adc_seq_checker #(.STANDBY_CONTROL_N_CYC(STANDBY_CONTROL_N_CYC), .SHUT_INT_CYC(SHUT_INT_CYC),
    .SHUT_EXT_CYC(SHUT_EXT_CYC), .RSTCN_CYC(RSTCN_CYC), .ACQ_CYC(ACQ_CYC)) chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .sample_req_i(sample_req_i), .sleep_req_i(sleep_req_i),
    .shutdown_exit_i(shutdown_exit_i), .ext_ref_i(ext_ref_i), .os_ratio_i(os_ratio_i),
    .busy_i(busy_i), .ready_o(ready_o), .convert_start_group_a_o(convert_start_group_a_o),
    .convert_start_group_b_o(convert_start_group_b_o), .standby_control_n_o(standby_control_n_o),
    .dev_reset_o(dev_reset_o), .oversample_ratio_select_o(oversample_ratio_select_o),
    .cs_n_o(cs_n_o), .sclk_o(sclk_o));
`default_nettype wire
